/* File: nvk_eeprom_writer.sv */
/*
  Nonvolatile memory write controller with APB register access: control,
  split address, unlock key, done flag and a table window onto the array.
  Assumes an array that reads with an acknowledge, latches single words and
  runs erase/program while ee_op_active is high; por_n is the power-up reset.
*/
`timescale 1ns/1ps
// Operation
// - Start needs key 0x55 then 0xAA written to the key register first.
// - EEPROM supports single words and sixteen-word block erase and program.
// - Target address is the high address byte joined with the low word.
// - Program takes about 2 ms; only hardware status marks completion.
// - Operations run in the background without stalling the processor.
// - Reads during an operation return undefined data.
// - Software can set start but not clear it; hardware clears on completion.
// - Permit bit gates starting and is clear after power-up.
// - Pin or watchdog reset during a write sets the error flag.
// - Such a reset leaves the low address register unchanged.
// - Completion sets the done flag; only software clears it.
// - Table read returns the word at table page plus pointer.
// - Erase takes about 2 ms; start clearing or done flag shows the end.
// - Start is ignored unless permit was set by an earlier write.
// - Clearing permit never aborts; hardware never clears permit.
module nvk_eeprom_writer
  import nvk_pkg::*;
#(
  parameter int unsigned PADDR_W = 18,
  parameter int unsigned CYCLES = OP_CYCLES,
  parameter int unsigned BLK_WORDS = BLOCK_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic reset_by_pin_or_watchdog,
  output logic [nvk_pkg::MEM_ADDR_W-1:0] ee_addr,
  output logic ee_rd_en,
  input wire logic [nvk_pkg::REG_W-1:0] ee_rd_data,
  input wire logic ee_rd_ack,
  output logic ee_lat_we,
  output logic [nvk_pkg::REG_W-1:0] ee_lat_data,
  output logic ee_op_go,
  output logic ee_op_active,
  output logic ee_op_erase,
  output logic ee_op_block,
  output logic ee_op_flash,
  output logic [nvk_pkg::MEM_ADDR_W-1:0] ee_op_addr
);
  import nvk_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  initial begin
    if (PADDR_W < 18 || PADDR_W > 32) begin
      $error("nvk_eeprom_writer: PADDR_W must lie in 18..32");
    end
    if (BLK_WORDS < 2 || BLK_WORDS > EE_MAX_WORDS || (BLK_WORDS & (BLK_WORDS - 1)) != 0) begin
      $error("nvk_eeprom_writer: BLK_WORDS must be a power of two that fits");
    end
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic [PADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = PADDR_W'({idx, 2'b00});
  endfunction

  logic sel_low;
  logic sel_high;
  logic sel_ctl;
  logic sel_key;
  logic sel_flag;
  logic sel_page;
  logic sel_ptr;
  logic sel_data;
  logic mapped;

  // One select per register; anything else answers with an error.
  assign sel_low = (paddr == byte_addr(IDX_ADDR_LOW));
  assign sel_high = (paddr == byte_addr(IDX_ADDR_HIGH));
  assign sel_ctl = (paddr == byte_addr(IDX_OP_CONTROL));
  assign sel_key = (paddr == byte_addr(IDX_UNLOCK_KEY));
  assign sel_flag = (paddr == byte_addr(IDX_FLAG_STATUS));
  assign sel_page = (paddr == byte_addr(IDX_TABLE_PAGE));
  assign sel_ptr = (paddr == byte_addr(IDX_TABLE_PTR));
  assign sel_data = (paddr == byte_addr(IDX_TABLE_DATA));
  assign mapped = sel_low | sel_high | sel_ctl | sel_key | sel_flag | sel_page |
                  sel_ptr | sel_data;

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  logic access;
  logic tbl_rd;
  logic tbl_done_r;
  logic fire;
  logic wr_fire;
  logic [15:0] wmask;

  // A table read stalls the access phase until the array answers.
  assign access = psel & penable;
  assign tbl_rd = access & ~pwrite & sel_data;
  assign pready = access & (~tbl_rd | tbl_done_r);
  assign pslverr = pready & ~mapped;
  assign fire = pready;
  assign wr_fire = fire & pwrite & mapped;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ---------------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------------
  nvk_ctl_if ctl ();

  nvk_key_seq u_key (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(ctl.keyer)
  );

  nvk_op_timer #(
    .CYCLES(CYCLES)
  ) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ctl(ctl.timer)
  );

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [15:0] addr_low_r;
  logic [HIGH_W-1:0] addr_high_r;
  logic start_r;
  logic permit_r;
  logic error_r;
  logic timed_r;
  logic [CTL_CODE_W-1:0] code_r;
  logic done_r;
  logic [HIGH_W-1:0] page_r;
  logic [15:0] ptr_r;
  logic mark_r;
  logic first_r;
  nvk_state_t state_r;
  logic [15:0] ctl_view;
  logic code_ok;
  logic start_req;
  logic go;
  logic tbl_wr;
  logic tbl_rd_hit;
  logic interrupted;

  // Decode of the operation code; unknown codes cannot start anything.
  always_comb begin
    code_ok = 1'b0;
    case (code_r)
      OP_EE_WORD_ERASE, OP_EE_BLOCK_ERASE, OP_EE_WORD_PROG,
      OP_EE_BLOCK_PROG, OP_FL_ROW_ERASE, OP_FL_ROW_PROG: begin
        code_ok = 1'b1;
      end
      default: begin
        code_ok = 1'b0;
      end
    endcase
  end

  // Start needs the key armed and permit already set before this write.
  assign start_req = wr_fire & sel_ctl & pstrb[1] & pwdata[CTL_START_BIT];
  assign go = start_req & ~start_r & ctl.armed & permit_r & code_ok & ~ctl.tmr_busy;
  assign tbl_wr = wr_fire & sel_data;
  assign tbl_rd_hit = tbl_rd & ee_rd_ack & ~tbl_done_r;
  assign interrupted = first_r & mark_r & reset_by_pin_or_watchdog;

  // Hooks into the key detector and the timer.
  assign ctl.wr_pulse = wr_fire;
  assign ctl.key_sel = sel_key & pstrb[0];
  assign ctl.key_data = pwdata[7:0];
  assign ctl.consume = go;
  assign ctl.tmr_start = go;

  // Address registers survive a warm reset so a failed location can be
  // retried; table accesses also capture their address here.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      addr_low_r <= '0;
      addr_high_r <= '0;
    end else if (tbl_wr || tbl_rd_hit) begin
      addr_low_r <= ptr_r;
      addr_high_r <= page_r;
    end else if (wr_fire && sel_low && !ctl.tmr_busy) begin
      addr_low_r <= merge(addr_low_r, pwdata[15:0], wmask);
    end else if (wr_fire && sel_high && pstrb[0] && !ctl.tmr_busy) begin
      addr_high_r <= pwdata[HIGH_W-1:0];
    end
  end

  // First cycle after a warm reset; used to inspect what the reset broke.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // Running-write mark and error flag live on power-up reset only, so a
  // warm reset in mid-operation leaves evidence behind.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mark_r <= 1'b0;
      error_r <= 1'b0;
    end else begin
      if (go) begin
        mark_r <= 1'b1;
      end else if (ctl.tmr_done || first_r) begin
        mark_r <= 1'b0;
      end
      if (interrupted) begin
        error_r <= 1'b1;
      end else if (wr_fire && sel_ctl && pstrb[1]) begin
        error_r <= pwdata[CTL_ERROR_BIT];
      end
    end
  end

  // Operation sequencer; idle until a legal start, running until the timer ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= NVK_IDLE;
    end else begin
      case (state_r)
        NVK_IDLE: begin
          if (go) begin
            state_r <= NVK_RUN;
          end
        end
        NVK_RUN: begin
          if (ctl.tmr_done) begin
            state_r <= NVK_IDLE;
          end
        end
        default: begin
          state_r <= NVK_IDLE;
        end
      endcase
    end
  end

  // Start bit: software may only set it, hardware clears it at completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= CTL_RESET[CTL_START_BIT];
    end else if (go) begin
      start_r <= 1'b1;
    end else if (ctl.tmr_done) begin
      start_r <= 1'b0;
    end
  end

  // Permit, timed select and code are plain software fields; hardware never
  // touches permit, and the code is frozen while an operation runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_r <= CTL_RESET[CTL_PERMIT_BIT];
      timed_r <= CTL_RESET[CTL_TIMED_BIT];
      code_r <= CTL_RESET[CTL_CODE_W-1:0];
    end else if (wr_fire && sel_ctl) begin
      if (pstrb[1]) begin
        permit_r <= pwdata[CTL_PERMIT_BIT];
        timed_r <= pwdata[CTL_TIMED_BIT];
      end
      if (pstrb[0] && !start_r) begin
        code_r <= pwdata[CTL_CODE_W-1:0];
      end
    end
  end

  // Done flag: completion sets it and wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (ctl.tmr_done) begin
      done_r <= 1'b1;
    end else if (wr_fire && sel_flag && pstrb[0]) begin
      done_r <= pwdata[FLAG_DONE_BIT];
    end
  end

  // Table page and pointer form the window onto the array.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= '0;
      ptr_r <= '0;
    end else begin
      if (wr_fire && sel_page && pstrb[0]) begin
        page_r <= pwdata[HIGH_W-1:0];
      end
      if (wr_fire && sel_ptr) begin
        ptr_r <= merge(ptr_r, pwdata[15:0], wmask);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Operation latch toward the array
  // ---------------------------------------------------------------------------
  logic op_erase_r;
  logic op_block_r;
  logic op_flash_r;
  logic [MEM_ADDR_W-1:0] op_addr_r;
  logic go_r;
  logic [MEM_ADDR_W-1:0] tgt_addr;
  logic tgt_block;

  // Block operations align down to the block; one word is two bytes.
  assign tgt_addr = {addr_high_r, addr_low_r};
  assign tgt_block = (code_r == OP_EE_BLOCK_ERASE) || (code_r == OP_EE_BLOCK_PROG) ||
                     code_r[0] && code_r[3:1] == 3'h0;

  // Selection is captured at start so later writes cannot disturb it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_erase_r <= 1'b0;
      op_block_r <= 1'b0;
      op_flash_r <= 1'b0;
      op_addr_r <= '0;
      go_r <= 1'b0;
    end else begin
      go_r <= go;
      if (go) begin
        op_erase_r <= code_r[6];
        op_block_r <= tgt_block;
        op_flash_r <= (code_r == OP_FL_ROW_ERASE) || (code_r == OP_FL_ROW_PROG);
        op_addr_r <= tgt_block ? (tgt_addr & ~MEM_ADDR_W'((BLK_WORDS << 1) - 1)) : tgt_addr;
      end
    end
  end

  assign ee_op_go = go_r;
  assign ee_op_active = (state_r == NVK_RUN);
  assign ee_op_erase = op_erase_r;
  assign ee_op_block = op_block_r;
  assign ee_op_flash = op_flash_r;
  assign ee_op_addr = op_addr_r;

  // ---------------------------------------------------------------------------
  // Table window
  // ---------------------------------------------------------------------------
  logic lat_we_r;
  logic [15:0] lat_data_r;

  // Word latch writes; a read stays requested until acknowledged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_we_r <= 1'b0;
      lat_data_r <= '0;
    end else begin
      lat_we_r <= tbl_wr;
      if (tbl_wr) begin
        lat_data_r <= merge(lat_data_r, pwdata[15:0], wmask);
      end
    end
  end

  assign ee_addr = {page_r, ptr_r};
  assign ee_rd_en = tbl_rd & ~tbl_done_r;
  assign ee_lat_we = lat_we_r;
  assign ee_lat_data = lat_data_r;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  assign ctl_view = {start_r, permit_r, error_r, 4'h0, timed_r, 1'b0, code_r};

  // Ordinary registers load in the setup cycle; the table data loads when
  // the array acknowledges, which may be mid-operation and then undefined.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      tbl_done_r <= 1'b0;
    end else begin
      if (fire) begin
        tbl_done_r <= 1'b0;
      end else if (tbl_rd_hit) begin
        tbl_done_r <= 1'b1;
        prdata <= {16'h0000, ee_rd_data};
      end
      if (psel && !penable && !pwrite) begin
        case (1'b1)
          sel_low: prdata <= {16'h0000, addr_low_r};
          sel_high: prdata <= {24'h000000, addr_high_r};
          sel_ctl: prdata <= {16'h0000, ctl_view};
          sel_flag: prdata <= {31'h00000000, done_r};
          sel_page: prdata <= {24'h000000, page_r};
          sel_ptr: prdata <= {16'h0000, ptr_r};
          default: prdata <= '0;
        endcase
      end
    end
  end

endmodule // nvk_eeprom_writer

/* File: nvk_pkg.sv */
/*
  Constants shared by the nonvolatile-memory write controller: register
  indices, control field positions, operation codes, key values and timing.
  Assumes a 20 MHz APB clock and a 16-bit register view.
*/
package nvk_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] IDX_ADDR_LOW = 16'h0762;
  localparam logic [15:0] IDX_ADDR_HIGH = 16'h0764;
  localparam logic [15:0] IDX_OP_CONTROL = 16'h0920;
  localparam logic [15:0] IDX_UNLOCK_KEY = 16'h9920;
  localparam logic [15:0] IDX_FLAG_STATUS = 16'h0790;
  localparam logic [15:0] IDX_TABLE_PAGE = 16'h07A0;
  localparam logic [15:0] IDX_TABLE_PTR = 16'h07A2;
  localparam logic [15:0] IDX_TABLE_DATA = 16'h07A4;
  localparam int unsigned IDX_SHIFT = 2;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int unsigned REG_W = 16;
  localparam int unsigned MEM_ADDR_W = 24;
  localparam int unsigned HIGH_W = 8;
  localparam int unsigned CTL_START_BIT = 15;
  localparam int unsigned CTL_PERMIT_BIT = 14;
  localparam int unsigned CTL_ERROR_BIT = 13;
  localparam int unsigned CTL_TIMED_BIT = 8;
  localparam int unsigned CTL_CODE_W = 7;
  localparam int unsigned FLAG_DONE_BIT = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] KEY_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Unlock key values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // ---------------------------------------------------------------------------
  // Operation codes of the control register's low field
  // ---------------------------------------------------------------------------
  localparam logic [6:0] OP_EE_WORD_ERASE = 7'h44;
  localparam logic [6:0] OP_EE_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_EE_WORD_PROG = 7'h04;
  localparam logic [6:0] OP_EE_BLOCK_PROG = 7'h0A;
  localparam logic [6:0] OP_FL_ROW_ERASE = 7'h41;
  localparam logic [6:0] OP_FL_ROW_PROG = 7'h01;

  // ---------------------------------------------------------------------------
  // Array geometry and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned BLOCK_WORDS = 16;
  localparam int unsigned EE_MAX_WORDS = 4096;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OP_TIME_US = 2000;
  localparam int unsigned OP_CYCLES = (OP_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum {
    NVK_IDLE,
    NVK_RUN
  } nvk_state_t;

endpackage

/* File: nvk_ctl_if.sv */
/*
  Interface joining the write controller to its unlock detector and its
  operation timer. Assumes all parties run on the same APB clock.
*/
`timescale 1ns/1ps
interface nvk_ctl_if;
  logic wr_pulse;
  logic key_sel;
  logic [7:0] key_data;
  logic consume;
  logic armed;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;

  modport keyer (
    input wr_pulse,
    input key_sel,
    input key_data,
    input consume,
    output armed
  );

  modport timer (
    input tmr_start,
    output tmr_busy,
    output tmr_done
  );

  modport ctrl (
    output wr_pulse,
    output key_sel,
    output key_data,
    output consume,
    input armed,
    output tmr_start,
    input tmr_busy,
    input tmr_done
  );
endinterface // nvk_ctl_if

/* File: nvk_key_seq.sv */
/*
  Unlock detector: watches register writes and arms after the two key values
  arrive in consecutive writes. Assumes one-cycle write pulses on pclk.
*/
`timescale 1ns/1ps
module nvk_key_seq
  import nvk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  nvk_ctl_if.keyer ctl
);

  typedef enum {
    NVK_KEY_NONE,
    NVK_KEY_HALF,
    NVK_KEY_ARMED
  } nvk_key_t;

  nvk_key_t key_r;

  // Any intervening write breaks the sequence, so a stray store cannot arm.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_r <= NVK_KEY_NONE;
    end else if (ctl.consume) begin
      key_r <= NVK_KEY_NONE;
    end else if (ctl.wr_pulse) begin
      case (key_r)
        NVK_KEY_NONE: begin
          key_r <= (ctl.key_sel && ctl.key_data == KEY_FIRST) ? NVK_KEY_HALF : NVK_KEY_NONE;
        end
        NVK_KEY_HALF: begin
          key_r <= (ctl.key_sel && ctl.key_data == KEY_SECOND) ? NVK_KEY_ARMED :
                   (ctl.key_sel && ctl.key_data == KEY_FIRST) ? NVK_KEY_HALF : NVK_KEY_NONE;
        end
        NVK_KEY_ARMED: begin
          // Armed lasts only until the next write, which must be the start.
          key_r <= (ctl.key_sel && ctl.key_data == KEY_FIRST) ? NVK_KEY_HALF : NVK_KEY_NONE;
        end
        default: begin
          key_r <= NVK_KEY_NONE;
        end
      endcase
    end
  end

  assign ctl.armed = (key_r == NVK_KEY_ARMED);

endmodule // nvk_key_seq

/* File: nvk_op_timer.sv */
/*
  Operation timer: counts the program or erase duration after a start pulse
  and pulses done at the end. Assumes the start pulse only comes when idle.
*/
`timescale 1ns/1ps
module nvk_op_timer
  import nvk_pkg::*;
#(
  parameter int unsigned CYCLES = OP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  nvk_ctl_if.timer ctl
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_r;
  logic busy_r;

  initial begin
    if (CYCLES < 2) begin
      $error("nvk_op_timer: CYCLES must be at least 2");
    end
  end

  // Countdown; the processor keeps running meanwhile, nothing here stalls it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (ctl.tmr_start && !busy_r) begin
      cnt_r <= LOAD;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  assign ctl.tmr_busy = busy_r;
  assign ctl.tmr_done = busy_r && (cnt_r == '0);

endmodule // nvk_op_timer

/* File: nvk_asserts.sv */
/* Port checker for the nonvolatile write controller.
   Assumes it is bound onto nvk_eeprom_writer and sees its ports only. */
`timescale 1ns/1ps
module nvk_asserts
  import nvk_pkg::*;
#(
  parameter int unsigned PADDR_W = 18,
  parameter int unsigned CYCLES = OP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic ee_rd_en,
  input wire logic ee_rd_ack,
  input wire logic ee_op_go,
  input wire logic ee_op_active,
  input wire logic ee_op_block,
  input wire logic [nvk_pkg::MEM_ADDR_W-1:0] ee_op_addr
);
  localparam logic [PADDR_W-1:0] TDA = PADDR_W'({IDX_TABLE_DATA, 2'b00});
  int run_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_run;
    ee_op_active [*8];
  endsequence
  // Counts active cycles; a slack of one allows for where the start edge is counted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_r <= 0;
    else run_r <= ee_op_active ? run_r + 1 : 0;
  end
  chk_go_active: assert property (ee_op_go |-> $rose(ee_op_active))
    else $error("start pulse without a run");
  chk_run_hold: assert property (ee_op_go |-> s_run)
    else $error("run ended early");
  chk_run_len: assert property ($fell(ee_op_active) |-> run_r >= CYCLES - 1
    && run_r <= CYCLES + 1) else $error("run length wrong");
  chk_no_restart: assert property ($past(ee_op_active) |-> !ee_op_go)
    else $error("start while busy");
  chk_op_held: assert property (ee_op_active && !ee_op_go |-> $stable(ee_op_addr))
    else $error("target moved during a run");
  chk_blk_align: assert property (ee_op_go && ee_op_block |-> ee_op_addr[4:0] == 5'h00)
    else $error("block target not aligned");
  chk_rd_answer: assert property (ee_rd_en && ee_rd_ack |=> pready && !ee_rd_en)
    else $error("array read not answered");
  chk_fast_ready: assert property (psel && penable && (pwrite || paddr != TDA) |-> pready)
    else $error("register access stalled");
endmodule // nvk_asserts

bind nvk_eeprom_writer nvk_asserts #(.PADDR_W(PADDR_W), .CYCLES(CYCLES)) chk_u (.*);

/* File: nvk_array_model.sv */
/* Behavioural memory array: answers reads three cycles late.
   Assumes the controller holds its read enable until the acknowledge. */
`timescale 1ns/1ps
module nvk_array_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] ee_addr,
  input wire logic ee_rd_en,
  output logic [15:0] ee_rd_data,
  output logic ee_rd_ack
);
  logic [1:0] cnt_r;
  // Idle data lines toggle every cycle so a stale word never passes for a fresh one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 2'h0;
      ee_rd_ack <= 1'b0;
      ee_rd_data <= 16'h0000;
    end else begin
      ee_rd_ack <= ee_rd_en && !ee_rd_ack && cnt_r == 2'h2;
      cnt_r <= (ee_rd_en && !ee_rd_ack) ? cnt_r + 2'h1 : 2'h0;
      ee_rd_data <= (ee_rd_en && cnt_r == 2'h2) ? ee_addr[15:0] ^ 16'hA5C3 : ~ee_rd_data;
    end
  end
endmodule // nvk_array_model

/* File: tb_top.sv */
/* Self-checking bench for the write controller and the array model.
   Assumes the operation timer is cut to 20 cycles. */
`timescale 1ns/1ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import nvk_pkg::*;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err, ee_rd_en;
  logic ee_rd_ack, ee_lat_we, ee_op_go, ee_op_active, ee_op_erase, ee_op_block, ee_op_flash;
  logic reset_by_pin_or_watchdog;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [23:0] ee_addr, ee_op_addr;
  logic [15:0] ee_rd_data, ee_lat_data;
  int bad_count, num_checks;
  nvk_eeprom_writer #(.CYCLES(20)) dut_u (.*);
  nvk_array_model mem_u (.*);
  task automatic conclude;
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [15:0] i, input logic [15:0] d);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, 16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin bad_count++; conclude(); end
    {psel, penable} <= 2'b00;
  endtask
  // Bounded wait for a running operation to end before the next start.
  task automatic wait_idle;
    int n;
    n = 0;
    while (ee_op_active === 1'b1) begin
      @(posedge pclk);
      n++;
      if (n >= 100) begin bad_count++; conclude(); end
    end
  endtask
  task automatic start(input logic [6:0] c);
    apb(1'b1, IDX_OP_CONTROL, {9'h080, c});
    apb(1'b1, IDX_UNLOCK_KEY, {8'h00, KEY_FIRST});
    apb(1'b1, IDX_UNLOCK_KEY, {8'h00, KEY_SECOND});
    apb(1'b1, IDX_OP_CONTROL, {9'h180, c});
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_gate;
    apb(1'b0, IDX_OP_CONTROL, 16'h0000);
    `CK(rd[15:0], CTL_RESET)
    start(OP_EE_BLOCK_ERASE);
    apb(1'b0, IDX_OP_CONTROL, 16'h0000);
    `CK({ee_op_active, rd[15:0]}, {1'b1, 16'hC045})
    apb(1'b1, IDX_OP_CONTROL, 16'hC045);
    apb(1'b0, IDX_UNLOCK_KEY, 16'h0000);
    `CK({err, rd[15:0]}, {1'b0, KEY_RESET})
    apb(1'b0, 16'h0100, 16'h0000);
    `CK({err, rd}, {1'b1, 32'h0})
    wait_idle();
  endtask
  // Every operation code runs once; clearing start and permit mid-run must not abort.
  task automatic t_ops;
    logic [6:0] c [6] = '{OP_EE_WORD_ERASE, OP_EE_BLOCK_ERASE, OP_EE_WORD_PROG,
      OP_EE_BLOCK_PROG, OP_FL_ROW_ERASE, OP_FL_ROW_PROG};
    logic [2:0] m [6] = '{3'b010, 3'b011, 3'b000, 3'b001, 3'b111, 3'b101};
    apb(1'b1, IDX_ADDR_HIGH, 16'h007F);
    apb(1'b1, IDX_ADDR_LOW, 16'hF01A);
    for (int k = 0; k < 6; k++) begin
      start(c[k]);
      #1;
      `CK({ee_op_flash, ee_op_erase, ee_op_block, ee_op_addr}, {m[k], m[k][0] ? 24'h7FF000 : 24'h7FF01A})
      apb(1'b1, IDX_OP_CONTROL, {9'h000, c[k]});
      apb(1'b0, IDX_OP_CONTROL, 16'h0000);
      `CK(rd[15:0], {9'h100, c[k]})
      wait_idle();
      apb(1'b0, IDX_OP_CONTROL, 16'h0000);
      `CK(rd[15], 1'b0)
      apb(1'b0, IDX_FLAG_STATUS, 16'h0000);
      `CK(rd[0], 1'b1)
      apb(1'b1, IDX_FLAG_STATUS, 16'h0000);
      apb(1'b0, IDX_FLAG_STATUS, 16'h0000);
      `CK(rd[0], 1'b0)
    end
  endtask
  task automatic t_table;
    apb(1'b1, IDX_TABLE_PAGE, 16'h007F);
    apb(1'b1, IDX_TABLE_PTR, 16'hF024);
    apb(1'b1, IDX_TABLE_DATA, 16'h5A3C);
    #1;
    `CK(ee_lat_we, 1'b1)
    apb(1'b0, IDX_TABLE_DATA, 16'h0000);
    `CK({ee_lat_data, rd[15:0]}, {16'h5A3C, 16'hF024 ^ 16'hA5C3})
  endtask
  // A warm reset in mid-run must flag the error only for a pin or watchdog source, and keep the address.
  task automatic t_abort;
    for (int r = 0; r < 2; r++) begin
      reset_by_pin_or_watchdog <= r[0];
      start(OP_EE_WORD_ERASE);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IDX_OP_CONTROL, 16'h0000);
      `CK({ee_op_active, rd[13]}, {1'b0, r[0]})
      apb(1'b0, IDX_ADDR_LOW, 16'h0000);
      `CK(rd[15:0], 16'hF024)
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, por_n, psel, penable, pwrite, paddr, pwdata} = '0;
    reset_by_pin_or_watchdog = 1'b1;
    pstrb = 4'h3;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge pclk);
    {presetn, por_n} <= 2'b11;
    t_gate();
    t_ops();
    t_table();
    t_abort();
    conclude();
  end
endmodule // tb_top
